// [pkg/spp_defines.svh]
// Opcodes, frame lengths, reset values, geometry and timing of the sector protect unit.
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define SPP_OP_WRITE_ENABLE     8'h06
`define SPP_OP_GANG_LOCK        8'h7E
`define SPP_OP_GANG_UNLOCK      8'h98
`define SPP_OP_READ_DYN         8'hE0
`define SPP_OP_WRITE_DYN        8'hE1
`define SPP_OP_SOLID_PROGRAM    8'hE3
`define SPP_OP_SOLID_ERASE      8'hE4
`define SPP_OP_SOLID_MASK       8'hE5
`define SPP_OP_PWD_READ         8'h27
`define SPP_OP_PWD_WRITE        8'h28
`define SPP_OP_PWD_UNLOCK       8'h29

// ----------------------------------------------------------------------
// Whole bytes in a frame, opcode included
// ----------------------------------------------------------------------
`define SPP_LEN_OPCODE          4'h1
`define SPP_LEN_MASK            4'h2
`define SPP_LEN_ADDR            4'h4
`define SPP_LEN_WRITE_DYN       4'h5
`define SPP_LEN_PWD             4'h9
`define SPP_LEN_MAX             4'hF

// ----------------------------------------------------------------------
// Reset values and answer bytes
// ----------------------------------------------------------------------
`define SPP_MASK_RST            1'b1
`define SPP_PWD_RST             64'hFFFF_FFFF_FFFF_FFFF
`define SPP_BYTE_PROT           8'hFF
`define SPP_BYTE_UNPROT         8'h00
`define SPP_OE_SPI              4'h2
`define SPP_OE_QPI              4'hF

// ----------------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------------
`define SPP_BLOCK_LSB           16
`define SPP_SECTOR_LSB          12
`define SPP_CLK_MHZ             100
`define SPP_UNLOCK_US           2
`define SPP_PENALTY_US          100

`endif

// [pkg/spp_pkg.sv]
// Types shared by the sector protect unit.
package spp_pkg;

	// ------------------------------------------------------------------
	// Frame state, Gray coded along idle, opcode, payload, output
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_OPCODE  = 2'b01,
		ST_PAYLOAD = 2'b11,
		ST_OUTPUT  = 2'b10
	} spp_state_t;

	// ------------------------------------------------------------------
	// Pins and straps that cross into the system clock domain
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] sio;
		logic       quad;
		logic       scheme_sel;
		logic       pwd_mode;
	} spp_pins_t;

endpackage

// [rtl/spp_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous levels.
module spp_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta;

	// ------------------------------------------------------------------
	// The first stage feeds only the second stage.
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= RESET_VAL;
			dout <= RESET_VAL;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule // spp_sync

// [rtl/spp_timer.sv]
// Load-and-count-down timer that reports busy and a done pulse.
module spp_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Control
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	// Status
	output logic              busy,
	output logic              done
);

	logic [W-1:0] count;

	if (W < 2) begin : g_bad_width
		$error("spp_timer needs at least two bits");
	end

	// ------------------------------------------------------------------
	// A start while busy is dropped; a load of n gives done n cycles on.
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				count <= load;
				busy  <= 1'b1;
			end else if (busy) begin
				if (count <= W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - W'(1);
				end
			end
		end
	end

endmodule // spp_timer

// [rtl/spp_top.sv]
// Sector protect and password unit behind the serial command link.
// What this block does
// - One volatile dynamic bit per 4KB end sector, per 64KB block elsewhere.
// - Protected when dynamic bit is 1, or solid bit and mask both 1.
// - Every reset sets all dynamic bits to 1.
// - Write-dynamic command sets or clears one addressed bit.
// - Opcode 7Eh sets all dynamic bits, 98h clears them, opcode-only frames.
// - Read-dynamic returns 00h for a clear bit, FFh for a set one.
// - Gang commands act only while the scheme select input is 1.
// - Gang commands are rejected unless chip select rises on a byte boundary.
// - Gang commands work in single-line and four-line command mode.
// - Solid mask resets to 1; while 0 solid bits are ignored.
// - In password mode reset leaves the solid-bit lock at 0.
// - Correct unlock sets the solid-bit lock; busy clears at completion.
// - Password written by write command, read back until mode is locked.
// - After password mode locks, password is neither readable nor writable.
// - Password starts all ones; writes only clear bits.
// - Wrong password sets the failure flag and holds busy 100us.
// - Correct password skips the penalty and leaves failure flag at 0.
// - In password mode, without a prior password write the solid-bit lock never becomes 1.
// - While the solid-bit lock is 0 solid bit program and erase are ignored; the mask command still acts.
`include "spp_defines.svh"

module spp_top #(
	parameter int NUM_BLOCKS     = 256,
	parameter int PENALTY_CYCLES = `SPP_PENALTY_US * `SPP_CLK_MHZ
) (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	// Serial command link
	input  wire logic        CS_N,
	input  wire logic        SCLK,
	input  wire logic [3:0]  SIO_IN,
	output logic      [3:0]  SIO_OUT,
	output logic      [3:0]  SIO_OE,
	// Mode levels
	input  wire logic        QUAD_MODE,
	input  wire logic        PROT_SCHEME_SEL,
	input  wire logic        PWD_MODE_LOCKED,
	// Protection query from the array controller
	input  wire logic [23:0] QUERY_ADDR,
	output logic             QUERY_PROT,
	// Status
	output logic             WRITE_IN_PROGRESS,
	output logic             PROT_FAIL,
	output logic             WRITE_ENABLE_LATCH,
	output logic             SOLID_BIT_LOCK
);

	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int BLK_W      = $clog2(NUM_BLOCKS);
	localparam int NBITS      = NUM_BLOCKS + 30;
	localparam int IDX_W      = $clog2(NBITS);
	localparam int TMR_W      = 16;
	localparam int UNLOCK_CYC = `SPP_UNLOCK_US * `SPP_CLK_MHZ;

	if (NUM_BLOCKS < 4 || NUM_BLOCKS > 256 || (1 << BLK_W) != NUM_BLOCKS) begin : g_bad_blocks
		$error("NUM_BLOCKS must be a power of two from 4 to 256");
	end
	if (PENALTY_CYCLES < 2 || PENALTY_CYCLES > (1 << TMR_W)) begin : g_bad_penalty
		$error("PENALTY_CYCLES does not fit the timer");
	end

	// End blocks are split into 16 sectors; middle blocks keep one bit each.
	function automatic logic [IDX_W-1:0] sector_index(input logic [23:0] a);
		logic [BLK_W-1:0] blk;
		logic [3:0]       sec;
		blk = a[`SPP_BLOCK_LSB +: BLK_W];
		sec = a[`SPP_SECTOR_LSB +: 4];
		if (blk == '0) begin
			return IDX_W'(sec);
		end else if (blk == BLK_W'(NUM_BLOCKS - 1)) begin
			return IDX_W'(NUM_BLOCKS + 14) + IDX_W'(sec);
		end else begin
			return IDX_W'(blk) + IDX_W'(15);
		end
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisation and edge detection
	// ------------------------------------------------------------------
	spp_pkg::spp_pins_t pins_raw;
	spp_pkg::spp_pins_t pins;
	logic               sclk_d;
	logic               cs_d;

	assign pins_raw = '{cs_n: CS_N, sclk: SCLK, sio: SIO_IN, quad: QUAD_MODE,
	                    scheme_sel: PROT_SCHEME_SEL, pwd_mode: PWD_MODE_LOCKED};

	spp_sync #(
		.WIDTH     ($bits(spp_pkg::spp_pins_t)),
		.RESET_VAL (9'h100)
	) u_sync (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.din   (pins_raw),
		.dout  (pins)
	);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sclk_d <= pins.sclk;
			cs_d   <= pins.cs_n;
		end
	end

	logic       selected;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_rise;
	logic [3:0] step;

	assign selected  = !pins.cs_n;
	assign sclk_rise = selected && pins.sclk && !sclk_d;
	assign sclk_fall = selected && !pins.sclk && sclk_d;
	assign cs_rise   = pins.cs_n && !cs_d;
	assign step      = pins.quad ? 4'h4 : 4'h1;

	// ------------------------------------------------------------------
	// Byte assembly
	// ------------------------------------------------------------------
	logic [7:0]  shreg;
	logic [3:0]  bitcnt;
	logic [3:0]  byte_cnt;
	logic [7:0]  opcode;
	logic [23:0] addr;
	logic [63:0] data;
	logic [7:0]  next_shift;
	logic [3:0]  next_bits;
	logic        byte_done;

	assign next_shift = pins.quad ? {shreg[3:0], pins.sio} : {shreg[6:0], pins.sio[0]};
	assign next_bits  = bitcnt + step;
	assign byte_done  = sclk_rise && (next_bits == 4'h8);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			shreg  <= '0;
			bitcnt <= '0;
		end else if (!selected) begin
			bitcnt <= '0;
		end else if (sclk_rise) begin
			shreg  <= next_shift;
			bitcnt <= byte_done ? 4'h0 : next_bits;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			byte_cnt <= '0;
		end else if (!selected) begin
			byte_cnt <= '0;
		end else if (byte_done && byte_cnt != `SPP_LEN_MAX) begin
			byte_cnt <= byte_cnt + 4'h1;
		end
	end

	// The first payload byte lands in the low byte of data after eight bytes.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			opcode <= '0;
			addr   <= '0;
			data   <= '0;
		end else if (byte_done) begin
			if (byte_cnt == 4'h0) begin
				opcode <= next_shift;
			end else begin
				data <= {next_shift, data[63:8]};
				if (byte_cnt < `SPP_LEN_ADDR) begin
					addr <= {addr[15:0], next_shift};
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Frame state
	// ------------------------------------------------------------------
	spp_pkg::spp_state_t state;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= spp_pkg::ST_IDLE;
		end else if (!selected) begin
			state <= spp_pkg::ST_IDLE;
		end else begin
			case (state)
				spp_pkg::ST_IDLE: begin
					state <= spp_pkg::ST_OPCODE;
				end
				spp_pkg::ST_OPCODE: begin
					if (byte_done) begin
						if (next_shift == `SPP_OP_PWD_READ && !pins.pwd_mode) begin
							state <= spp_pkg::ST_OUTPUT;
						end else begin
							state <= spp_pkg::ST_PAYLOAD;
						end
					end
				end
				spp_pkg::ST_PAYLOAD: begin
					if (byte_done && opcode == `SPP_OP_READ_DYN &&
					    byte_cnt == `SPP_LEN_ADDR - 4'h1) begin
						state <= spp_pkg::ST_OUTPUT;
					end
				end
				default: begin
					state <= spp_pkg::ST_OUTPUT;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Command execution at the closing chip select edge
	// ------------------------------------------------------------------
	logic [NBITS-1:0] dyn_bits;
	logic [NBITS-1:0] solid_bits;
	logic             solid_mask;
	logic [63:0]      pwd;
	logic             pwd_written;
	logic             unlock_ok;
	logic             tmr_busy;
	logic             tmr_done;
	logic             exec;
	logic             mod_ok;
	logic             pwd_match;
	logic [IDX_W-1:0] cmd_idx;

	// A partial trailing byte leaves the frame unexecuted.
	assign exec      = cs_rise && state != spp_pkg::ST_IDLE && bitcnt == 4'h0;
	assign mod_ok    = exec && WRITE_ENABLE_LATCH && !WRITE_IN_PROGRESS;
	assign pwd_match = (data == pwd) && pwd_written;
	assign cmd_idx   = sector_index(addr);

	logic do_write_enable_cmd;
	logic do_gang_lock;
	logic do_gang_unlock;
	logic do_write_dyn;
	logic do_mask;
	logic do_solid_prog;
	logic do_solid_erase;
	logic do_pwd_write;
	logic do_unlock;
	logic is_mod_op;

	assign do_write_enable_cmd        = exec && opcode == `SPP_OP_WRITE_ENABLE && byte_cnt == `SPP_LEN_OPCODE;
	assign do_gang_lock   = mod_ok && pins.scheme_sel && opcode == `SPP_OP_GANG_LOCK &&
	                        byte_cnt == `SPP_LEN_OPCODE;
	assign do_gang_unlock = mod_ok && pins.scheme_sel && opcode == `SPP_OP_GANG_UNLOCK &&
	                        byte_cnt == `SPP_LEN_OPCODE;
	assign do_write_dyn   = mod_ok && opcode == `SPP_OP_WRITE_DYN &&
	                        byte_cnt == `SPP_LEN_WRITE_DYN;
	assign do_mask        = mod_ok && opcode == `SPP_OP_SOLID_MASK && byte_cnt == `SPP_LEN_MASK;
	assign do_solid_prog  = mod_ok && SOLID_BIT_LOCK && opcode == `SPP_OP_SOLID_PROGRAM &&
	                        byte_cnt == `SPP_LEN_ADDR;
	assign do_solid_erase = mod_ok && SOLID_BIT_LOCK && opcode == `SPP_OP_SOLID_ERASE &&
	                        byte_cnt == `SPP_LEN_OPCODE;
	assign do_pwd_write   = mod_ok && !pins.pwd_mode && opcode == `SPP_OP_PWD_WRITE &&
	                        byte_cnt == `SPP_LEN_PWD;
	assign do_unlock      = mod_ok && opcode == `SPP_OP_PWD_UNLOCK && byte_cnt == `SPP_LEN_PWD;
	assign is_mod_op      = cs_rise && state != spp_pkg::ST_IDLE &&
	                        (opcode == `SPP_OP_GANG_LOCK || opcode == `SPP_OP_GANG_UNLOCK ||
	                         opcode == `SPP_OP_WRITE_DYN || opcode == `SPP_OP_SOLID_MASK ||
	                         opcode == `SPP_OP_SOLID_PROGRAM || opcode == `SPP_OP_SOLID_ERASE ||
	                         opcode == `SPP_OP_PWD_WRITE || opcode == `SPP_OP_PWD_UNLOCK);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			WRITE_ENABLE_LATCH <= 1'b0;
		end else if (do_write_enable_cmd) begin
			WRITE_ENABLE_LATCH <= 1'b1;
		end else if (is_mod_op) begin
			WRITE_ENABLE_LATCH <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			dyn_bits <= '1;
		end else if (do_gang_lock) begin
			dyn_bits <= '1;
		end else if (do_gang_unlock) begin
			dyn_bits <= '0;
		end else if (do_write_dyn) begin
			dyn_bits[cmd_idx] <= (data[63:56] != `SPP_BYTE_UNPROT);
		end
	end

	// Solid bits are kept here as plain flops; their slow program cycle is not modelled.
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			solid_bits <= '0;
		end else if (do_solid_erase) begin
			solid_bits <= '0;
		end else if (do_solid_prog) begin
			solid_bits[cmd_idx] <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			solid_mask <= `SPP_MASK_RST;
		end else if (do_mask) begin
			solid_mask <= data[56];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pwd         <= `SPP_PWD_RST;
			pwd_written <= 1'b0;
		end else if (do_pwd_write) begin
			pwd         <= pwd & data;
			pwd_written <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Password unlock, penalty timer and solid-bit lock
	// ------------------------------------------------------------------
	spp_timer #(
		.W (TMR_W)
	) u_timer (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.start (do_unlock),
		// Loaded one short, because busy falls a cycle after the timer's done pulse.
		.load  (pwd_match ? TMR_W'(UNLOCK_CYC - 1) : TMR_W'(PENALTY_CYCLES - 1)),
		.busy  (tmr_busy),
		.done  (tmr_done)
	);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			WRITE_IN_PROGRESS       <= 1'b0;
			unlock_ok <= 1'b0;
		end else if (do_unlock) begin
			WRITE_IN_PROGRESS       <= 1'b1;
			unlock_ok <= pwd_match;
		end else if (tmr_done) begin
			WRITE_IN_PROGRESS <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PROT_FAIL <= 1'b0;
		end else if (do_unlock) begin
			PROT_FAIL <= !pwd_match;
		end
	end

	// The mode strap is caught only once the synchroniser has settled after reset.
	logic [1:0] init_cnt;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			init_cnt <= '0;
		end else if (init_cnt != 2'h3) begin
			init_cnt <= init_cnt + 2'h1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SOLID_BIT_LOCK <= 1'b0;
		end else if (init_cnt == 2'h2) begin
			SOLID_BIT_LOCK <= !pins.pwd_mode;
		end else if (tmr_done && unlock_ok) begin
			SOLID_BIT_LOCK <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Read answers, shifted out on falling serial clock edges
	// ------------------------------------------------------------------
	logic [7:0] out_shift;
	logic [3:0] out_bits;
	logic [2:0] out_idx;
	logic [7:0] cur_byte;
	logic [7:0] src;
	logic       load_byte;

	always_comb begin
		if (opcode == `SPP_OP_READ_DYN) begin
			cur_byte = dyn_bits[cmd_idx] ? `SPP_BYTE_PROT : `SPP_BYTE_UNPROT;
		end else begin
			cur_byte = pwd[{out_idx, 3'b000} +: 8];
		end
	end

	assign load_byte = (out_bits == 4'h0);
	assign src       = load_byte ? cur_byte : out_shift;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SIO_OUT   <= '0;
			SIO_OE    <= '0;
			out_shift <= '0;
			out_bits  <= '0;
			out_idx   <= '0;
		end else if (state != spp_pkg::ST_OUTPUT || !selected) begin
			SIO_OUT  <= '0;
			SIO_OE   <= '0;
			out_bits <= '0;
			out_idx  <= '0;
		end else if (sclk_fall) begin
			SIO_OUT   <= pins.quad ? src[7:4] : {2'b00, src[7], 1'b0};
			SIO_OE    <= pins.quad ? `SPP_OE_QPI : `SPP_OE_SPI;
			out_shift <= pins.quad ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
			out_bits  <= (load_byte ? 4'h8 : out_bits) - step;
			if (load_byte) begin
				out_idx <= out_idx + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Protection query for program and erase
	// ------------------------------------------------------------------
	logic [IDX_W-1:0] query_idx;

	assign query_idx = sector_index(QUERY_ADDR);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			QUERY_PROT <= 1'b1;
		end else begin
			QUERY_PROT <= dyn_bits[query_idx] ||
			              (solid_bits[query_idx] && solid_mask);
		end
	end

endmodule // spp_top

// [testbench/spp_top_properties.sv]
// Port-level assertions for the sector protect unit.
module spp_top_properties #(
	parameter int PENALTY_CYCLES = 10000
) (
	input wire logic       SYS_CLK,
	input wire logic       RST_N,
	input wire logic       CS_N,
	input wire logic [3:0] SIO_OE,
	input wire logic       PWD_MODE_LOCKED,
	input wire logic       QUERY_PROT,
	input wire logic       WRITE_IN_PROGRESS,
	input wire logic       PROT_FAIL,
	input wire logic       WRITE_ENABLE_LATCH,
	input wire logic       SOLID_BIT_LOCK
);
	// The penalty is too long to unroll, so a counter measures each busy spell.
	int wip_len;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			wip_len <= 0;
		else
			wip_len <= WRITE_IN_PROGRESS ? wip_len + 1 : 0;
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_reset_all_prot: assert property ($rose(RST_N) |-> QUERY_PROT [*3])
		else $error("sector open after reset");
	a_busy_length: assert property ($fell(WRITE_IN_PROGRESS) |->
		wip_len == (PROT_FAIL ? PENALTY_CYCLES : 200)) else $error("busy length wrong");
	a_fail_busy: assert property ($rose(PROT_FAIL) |-> WRITE_IN_PROGRESS [*8])
		else $error("failure without busy");
	a_fail_cause: assert property ($changed(PROT_FAIL) |-> $rose(WRITE_IN_PROGRESS))
		else $error("failure flag moved outside unlock");
	a_lock_by_unlock: assert property ($rose(SOLID_BIT_LOCK) && PWD_MODE_LOCKED |->
		$fell(WRITE_IN_PROGRESS) && !PROT_FAIL) else $error("lock opened without good unlock");
	a_lock_after_reset: assert property ($rose(RST_N) |->
		##4 (SOLID_BIT_LOCK == !PWD_MODE_LOCKED)) else $error("lock reset value wrong");
	a_wel_cleared: assert property ($rose(WRITE_IN_PROGRESS) |-> !WRITE_ENABLE_LATCH)
		else $error("latch kept after unlock");
	a_oe_idle: assert property (CS_N [*5] |-> SIO_OE == 4'h0)
		else $error("driving while deselected");
endmodule // spp_top_properties

// [testbench/spp_host_model.sv]
// Host controller model that frames commands on the serial link.
`include "spp_defines.svh"
module spp_host_model (
	// Timing reference
	input  wire logic       clk,
	// Link
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] sio,
	input  wire logic [3:0] sio_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] rdata = '0;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sio = 4'h5;
	end

	task automatic half();
		repeat (8) @(posedge clk);
	endtask

	// Sends n bytes, MSB first; cut drops trailing bits to break a frame.
	task automatic frame(input int n, input logic [71:0] d, input int rb, input bit q,
		input int cut);
		int i;
		@(posedge clk) cs_n <= 1'b0;
		for (i = 8 * n - 1; i >= cut; i -= (q ? 4 : 1)) begin
			sio <= q ? d[i-:4] : {~sio[3:1], d[i]};
			half();
			sclk <= 1'b1;
			half();
			sclk <= 1'b0;
		end
		for (i = 0; i < 8 * rb; i++) begin
			half();
			sclk <= 1'b1;
			rdata <= {rdata[62:0], sio_out[1]};
			half();
			sclk <= 1'b0;
		end
		half();
		cs_n <= 1'b1;
		// Released lines toggle so a stale level is never mistaken for data.
		sio <= ~sio;
		repeat (20) @(posedge clk);
	endtask

	task automatic cmd(input int n, input logic [71:0] d, input bit q, input int cut);
		frame(1, 72'(`SPP_OP_WRITE_ENABLE), 0, q, 0);
		frame(n, d, 0, q, cut);
	endtask
endmodule // spp_host_model

// [testbench/tb_spp_top.sv]
// Self-checking bench for the sector protect unit.
`include "spp_defines.svh"
module tb_spp_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int          PEN = 50;
	localparam logic [63:0] PWD = 64'h00F0_1234_5678_9A0C;
	logic        sys_clk;
	logic        rst_n = 1'b0;
	logic        cs_n;
	logic        sclk;
	logic [3:0]  sio_in;
	logic [3:0]  sio_out;
	logic [3:0]  sio_oe;
	logic        quad = 1'b0;
	logic        sel = 1'b1;
	logic        pwd = 1'b0;
	logic [23:0] qaddr = '0;
	logic        qprot;
	logic        write_in_progress;
	logic        pfail;
	logic        write_enable_latch;
	logic        slock;
	logic [3:0]  oe_seen = 4'h0;
	int          wip_cnt = 0;
	int          num_errors = 0;
	int          tests_run = 0;

	spp_host_model host_model_i (.clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .sio(sio_in),
		.sio_out(sio_out));
	spp_top #(.PENALTY_CYCLES(PEN)) spp_top_i (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SIO_IN(sio_in),
		.SIO_OUT(sio_out), .SIO_OE(sio_oe), .QUAD_MODE(quad), .PROT_SCHEME_SEL(sel),
		.PWD_MODE_LOCKED(pwd), .QUERY_ADDR(qaddr), .QUERY_PROT(qprot), .WRITE_IN_PROGRESS(write_in_progress),
		.PROT_FAIL(pfail), .WRITE_ENABLE_LATCH(write_enable_latch), .SOLID_BIT_LOCK(slock));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		oe_seen <= oe_seen | sio_oe;
		if (write_in_progress === 1'b1)
			wip_cnt <= wip_cnt + 1;
	end

	function automatic logic [63:0] rev(input logic [63:0] v);
		return {<<8{v}};
	endfunction

	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic do_reset(input logic p);
		@(posedge sys_clk) rst_n <= 1'b0;
		pwd <= p;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic op(input int n, input logic [71:0] d);
		host_model_i.cmd(n, d, 1'b0, 0);
	endtask

	task automatic qry(input logic [23:0] a, input logic exp);
		@(posedge sys_clk) qaddr <= a;
		repeat (2) @(posedge sys_clk);
		#1 chk("query", 64'(qprot), 64'(exp));
	endtask

	task automatic rd_dyn(input logic [23:0] a, input logic [7:0] exp);
		#1 oe_seen = 4'h0;
		host_model_i.frame(4, 72'({`SPP_OP_READ_DYN, a}), 1, 1'b0, 0);
		chk("read_dyn", 64'(host_model_i.rdata[7:0]), 64'(exp));
		chk("read_oe", 64'(oe_seen), 64'(4'h2));
	endtask

	// Waits out the busy spell so the next unlock keeps its spacing.
	task automatic unlock(input logic [63:0] p);
		int i;
		#1 wip_cnt = 0;
		op(9, {`SPP_OP_PWD_UNLOCK, rev(p)});
		for (i = 0; i < 1000 && write_in_progress !== 1'b0; i++) begin
			@(posedge sys_clk);
			#1;
		end
		if (i == 1000) begin
			num_errors++;
			print_verdict();
		end
	endtask

	task automatic t_dynamic();
		rd_dyn(24'h001000, 8'hFF);
		op(5, 72'({`SPP_OP_WRITE_DYN, 24'h001000, 8'h00}));
		rd_dyn(24'h001000, 8'h00);
		qry(24'h001FFF, 1'b0);
		qry(24'h002000, 1'b1);
		op(5, 72'({`SPP_OP_WRITE_DYN, 24'hFF3000, 8'h00}));
		qry(24'hFF2FFF, 1'b1);
		op(5, 72'({`SPP_OP_WRITE_DYN, 24'h05A000, 8'h00}));
		qry(24'h050000, 1'b0);
		op(5, 72'({`SPP_OP_WRITE_DYN, 24'h05FFFF, 8'h3C}));
		qry(24'h05A000, 1'b1);
	endtask

	task automatic t_gang();
		@(posedge sys_clk) sel <= 1'b0;
		op(1, 72'(`SPP_OP_GANG_UNLOCK));
		qry(24'h002000, 1'b1);
		@(posedge sys_clk) sel <= 1'b1;
		host_model_i.cmd(2, 72'({`SPP_OP_GANG_UNLOCK, 8'h00}), 1'b0, 4);
		qry(24'h002000, 1'b1);
		host_model_i.frame(1, 72'(`SPP_OP_GANG_UNLOCK), 0, 1'b0, 0);
		qry(24'h002000, 1'b1);
		op(1, 72'(`SPP_OP_GANG_UNLOCK));
		qry(24'h002000, 1'b0);
		chk("wel", 64'(write_enable_latch), 64'(1'b0));
		@(posedge sys_clk) quad <= 1'b1;
		host_model_i.cmd(1, 72'(`SPP_OP_GANG_LOCK), 1'b1, 0);
		qry(24'h7F0000, 1'b1);
		host_model_i.cmd(1, 72'(`SPP_OP_GANG_UNLOCK), 1'b1, 0);
		qry(24'h7F0000, 1'b0);
		@(posedge sys_clk) quad <= 1'b0;
	endtask

	task automatic t_solid();
		op(4, 72'({`SPP_OP_SOLID_PROGRAM, 24'h100000}));
		qry(24'h10FFFF, 1'b1);
		op(2, 72'({`SPP_OP_SOLID_MASK, 8'h00}));
		qry(24'h100000, 1'b0);
		op(2, 72'({`SPP_OP_SOLID_MASK, 8'h01}));
		qry(24'h100000, 1'b1);
		op(1, 72'(`SPP_OP_SOLID_ERASE));
		qry(24'h100000, 1'b0);
	endtask

	task automatic t_password();
		op(9, {`SPP_OP_PWD_WRITE, rev(64'hF0F0_1234_5678_9ABC)});
		op(9, {`SPP_OP_PWD_WRITE, rev(64'h0FFF_FFFF_FFFF_FF0F)});
		host_model_i.frame(1, 72'(`SPP_OP_PWD_READ), 8, 1'b0, 0);
		chk("password", rev(host_model_i.rdata), PWD);
		unlock(~PWD);
		chk("fail", 64'(pfail), 64'(1'b1));
		chk("busy", 64'(wip_cnt), 64'(PEN));
		unlock(PWD);
		chk("fail", 64'(pfail), 64'(1'b0));
		chk("busy", 64'(wip_cnt), 64'(200));
	endtask

	task automatic t_pwd_mode();
		do_reset(1'b1);
		chk("lock", 64'(slock), 64'(1'b0));
		#1 oe_seen = 4'h0;
		host_model_i.frame(1, 72'(`SPP_OP_PWD_READ), 1, 1'b0, 0);
		chk("pwd_oe", 64'(oe_seen), 64'(4'h0));
		unlock(64'hFFFF_FFFF_FFFF_FFFF);
		chk("lock", 64'(slock), 64'(1'b0));
		op(1, 72'(`SPP_OP_GANG_UNLOCK));
		op(4, 72'({`SPP_OP_SOLID_PROGRAM, 24'h100000}));
		qry(24'h100000, 1'b0);
	endtask

	initial begin
		do_reset(1'b0);
		t_dynamic();
		t_gang();
		t_solid();
		t_password();
		t_pwd_mode();
		print_verdict();
	end
endmodule // tb_spp_top

bind spp_top spp_top_properties #(.PENALTY_CYCLES(PENALTY_CYCLES)) spp_top_properties_i (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CS_N(CS_N), .SIO_OE(SIO_OE),
	.PWD_MODE_LOCKED(PWD_MODE_LOCKED), .QUERY_PROT(QUERY_PROT), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
	.PROT_FAIL(PROT_FAIL), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
	.SOLID_BIT_LOCK(SOLID_BIT_LOCK));
